// *** rtl/fifo_port_ctl.sv ***
/*
 * Port control and status of a bus-matching FIFO: write and read ports,
 * offset registers, programmable flags, resets and retransmit.
 * Assumes every pin input is asynchronous to i_clock and toggles slower
 * than half its rate; straps are held steady after master reset.
 */
module fifo_port_ctl #(
    parameter int MEM_DEPTH = 512,
    parameter int BUF_DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Resets from the pins
    input wire logic i_master_reset_n,
    input wire logic i_partial_reset_n,
    // Configuration straps
    input wire logic i_read_port_width_sel,
    input wire logic i_flag_timing_sel,
    input wire logic i_retransmit_latency_sel,
    input wire logic i_read_port_sync_sel,
    input wire logic i_write_port_sync_sel,
    // Write port
    input wire logic i_write_clock,
    input wire logic i_write_enable_n,
    input wire logic [17:0] i_data_in,
    // Read port
    input wire logic i_read_clock,
    input wire logic i_read_enable_n,
    input wire logic i_output_enable_n,
    input wire logic i_retransmit_request_n,
    // Offset programming
    input wire logic i_offset_load_n,
    input wire logic i_serial_load_enable_n,
    input wire logic i_first_word_fall_through,
    // Data outputs
    output logic [17:0] o_data_out,
    output logic o_data_out_oe,
    // Status flags
    output logic o_empty_flag,
    output logic o_full_flag,
    output logic o_almost_empty_flag,
    output logic o_almost_full_flag
);

    localparam int DW = fifo_ctl_pkg::DATA_W;
    localparam int NW = fifo_ctl_pkg::NARROW_W;
    localparam int AW = $clog2(MEM_DEPTH);
    localparam int CW = $clog2(MEM_DEPTH + 1);
    localparam int RW = 2;

    typedef struct packed {
        logic mreset_n;
        logic preset_n;
        logic narrow_sel;
        logic sync_flag_sel;
        logic rt_lat_sel;
        logic asyr;
        logic asyw;
        logic wclk;
        logic wen_n;
        logic [17:0] din;
        logic rclk;
        logic ren_n;
        logic oe_n;
        logic rewind_n;
        logic off_load_n;
        logic ser_en_n;
        logic si;
    } pins_s;

    typedef struct packed {
        logic [MEM_DEPTH-1:0][DW-1:0] mem;
        pins_s meta;
        pins_s pin;
        logic wclk_prev;
        logic rclk_prev;
        logic fall_thru;
        logic narrow;
        logic sync_flags;
        logic normal_rt;
        logic serial_prog;
        logic rd_sync;
        logic wr_sync;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic [CW-1:0] empty_off;
        logic [CW-1:0] full_off;
        fifo_ctl_pkg::offset_sel_e wr_sel;
        fifo_ctl_pkg::offset_sel_e rd_sel;
        logic [DW-1:0] out_data;
        logic out_valid;
        logic [RW-1:0] rt_cnt;
        logic ae_now;
        logic af_now;
        logic ae_out;
        logic af_out;
    } state_s;

    state_s s_q;
    state_s s_d;
    pins_s pins_in;
    logic wr_rise;
    logic rd_rise;
    logic wr_evt;
    logic rd_evt;
    logic any_reset;
    logic buf_rstn;
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [DW-1:0] buf_out_data;
    logic mem_full;
    logic push;
    logic pop;
    logic [CW-1:0] free_cnt;

    // ----------------------------------------------------------------
    // Pin gathering and edge detection.
    // ----------------------------------------------------------------
    assign pins_in = '{
        mreset_n: i_master_reset_n,
        preset_n: i_partial_reset_n,
        narrow_sel: i_read_port_width_sel,
        sync_flag_sel: i_flag_timing_sel,
        rt_lat_sel: i_retransmit_latency_sel,
        asyr: i_read_port_sync_sel,
        asyw: i_write_port_sync_sel,
        wclk: i_write_clock,
        wen_n: i_write_enable_n,
        din: i_data_in,
        rclk: i_read_clock,
        ren_n: i_read_enable_n,
        oe_n: i_output_enable_n,
        rewind_n: i_retransmit_request_n,
        off_load_n: i_offset_load_n,
        ser_en_n: i_serial_load_enable_n,
        si: i_first_word_fall_through
    };

    assign wr_rise = s_q.pin.wclk && !s_q.wclk_prev;
    assign rd_rise = s_q.pin.rclk && !s_q.rclk_prev;
    // Strobe ports act on every rise; clocked ports need the enable.
    assign wr_evt = wr_rise && (!s_q.wr_sync || !s_q.pin.wen_n);
    assign rd_evt = rd_rise && (!s_q.rd_sync || !s_q.pin.ren_n);
    assign any_reset = !s_q.pin.mreset_n || !s_q.pin.preset_n;
    assign buf_rstn = i_rstn && !any_reset;

    assign mem_full = s_q.count == CW'(MEM_DEPTH);
    assign free_cnt = CW'(MEM_DEPTH) - s_q.count;
    // Memory words go to the staging buffer only while it and memory have room.
    assign buf_in_valid = wr_evt && s_q.pin.off_load_n && !mem_full;
    assign buf_out_ready = !mem_full && !any_reset;

    stream_buffer #(
        .WIDTH(DW),
        .DEPTH(BUF_DEPTH)
    ) u_stage (
        .i_clock(i_clock),
        .i_rstn(buf_rstn),
        .i_in_valid(buf_in_valid),
        .o_in_ready(buf_in_ready),
        .i_in_data(s_q.pin.din),
        .o_out_valid(buf_out_valid),
        .i_out_ready(buf_out_ready),
        .o_out_data(buf_out_data)
    );

    // ----------------------------------------------------------------
    // Next-state logic.
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        push = buf_out_valid && buf_out_ready;
        pop = 1'b0;
        s_d.meta = pins_in;
        s_d.pin = s_q.meta;
        s_d.wclk_prev = s_q.pin.wclk;
        s_d.rclk_prev = s_q.pin.rclk;
        if (s_q.rt_cnt != '0)
        begin
            s_d.rt_cnt = s_q.rt_cnt - RW'(1);
        end
        // Offset programming, steered by the load pin.
        if (!s_q.pin.off_load_n && !s_q.serial_prog && wr_evt)
        begin
            if (s_q.wr_sel == fifo_ctl_pkg::SEL_EMPTY_OFFSET)
            begin
                s_d.empty_off = s_q.pin.din[CW-1:0];
                s_d.wr_sel = fifo_ctl_pkg::SEL_FULL_OFFSET;
            end
            else
            begin
                s_d.full_off = s_q.pin.din[CW-1:0];
                s_d.wr_sel = fifo_ctl_pkg::SEL_EMPTY_OFFSET;
            end
        end
        if (s_q.serial_prog && !s_q.pin.ser_en_n && wr_rise)
        begin
            {s_d.full_off, s_d.empty_off} =
                {s_q.full_off[CW-2:0], s_q.empty_off, s_q.pin.si};
        end
        // Memory write from the staging buffer.
        if (push)
        begin
            s_d.mem[s_q.wr_ptr] = buf_out_data;
            s_d.wr_ptr = s_q.wr_ptr + AW'(1);
        end
        // Reads of the offset registers.
        if (!s_q.pin.off_load_n && rd_evt)
        begin
            s_d.out_data = (s_q.rd_sel == fifo_ctl_pkg::SEL_EMPTY_OFFSET)
                ? DW'(s_q.empty_off) : DW'(s_q.full_off);
            s_d.rd_sel = (s_q.rd_sel == fifo_ctl_pkg::SEL_EMPTY_OFFSET)
                ? fifo_ctl_pkg::SEL_FULL_OFFSET
                : fifo_ctl_pkg::SEL_EMPTY_OFFSET;
        end
        else if (!s_q.fall_thru)
        begin
            // Standard mode: each read event takes one word if present and no retransmit delay is running.
            if (rd_evt && s_q.count != '0 && s_q.rt_cnt == '0)
            begin
                pop = 1'b1;
            end
        end
        else if (s_q.rt_cnt == '0)
        begin
            // Fall-through: the head word waits at the outputs.
            if (s_q.count != '0 && (!s_q.out_valid || rd_evt))
            begin
                pop = 1'b1;
            end
            else if (rd_evt)
            begin
                s_d.out_valid = 1'b0;
            end
        end
        if (pop)
        begin
            s_d.out_data = s_q.mem[s_q.rd_ptr];
            s_d.out_valid = 1'b1;
            s_d.rd_ptr = s_q.rd_ptr + AW'(1);
        end
        s_d.count = s_q.count + CW'(push) - CW'(pop);
        // Retransmit rewinds the read side only.
        if (!s_q.pin.rewind_n && rd_rise)
        begin
            s_d.rd_ptr = '0;
            s_d.count = CW'(s_d.wr_ptr);
            s_d.out_valid = 1'b0;
            s_d.rt_cnt = s_q.normal_rt
                ? RW'(fifo_ctl_pkg::RT_NORMAL_LAT_CYCLES)
                : RW'(fifo_ctl_pkg::RT_ZERO_LAT_CYCLES);
        end
        // Flag evaluation; synchronous timing adds one register stage.
        s_d.ae_now = s_q.count >= s_q.empty_off;
        s_d.af_now = free_cnt > s_q.full_off;
        s_d.ae_out = s_q.sync_flags ? s_q.ae_now : s_d.ae_now;
        s_d.af_out = s_q.sync_flags ? s_q.af_now : s_d.af_now;
        // Partial reset clears data but keeps the programmed settings.
        if (!s_q.pin.preset_n)
        begin
            s_d.wr_ptr = '0;
            s_d.rd_ptr = '0;
            s_d.count = '0;
            s_d.out_data = '0;
            s_d.out_valid = 1'b0;
            s_d.rt_cnt = '0;
            s_d.wr_sel = fifo_ctl_pkg::SEL_EMPTY_OFFSET;
            s_d.rd_sel = fifo_ctl_pkg::SEL_EMPTY_OFFSET;
        end
        // Master reset clears data and latches every strap.
        if (!s_q.pin.mreset_n)
        begin
            s_d.wr_ptr = '0;
            s_d.rd_ptr = '0;
            s_d.count = '0;
            s_d.out_data = '0;
            s_d.out_valid = 1'b0;
            s_d.rt_cnt = '0;
            s_d.wr_sel = fifo_ctl_pkg::SEL_EMPTY_OFFSET;
            s_d.rd_sel = fifo_ctl_pkg::SEL_EMPTY_OFFSET;
            s_d.narrow = s_q.pin.narrow_sel;
            s_d.sync_flags = s_q.pin.sync_flag_sel;
            s_d.normal_rt = s_q.pin.rt_lat_sel;
            s_d.rd_sync = s_q.pin.asyr;
            s_d.wr_sync = s_q.pin.asyw;
            s_d.fall_thru = s_q.pin.si && s_q.pin.asyr;
            s_d.serial_prog = s_q.pin.off_load_n;
            s_d.empty_off = CW'(fifo_ctl_pkg::EMPTY_OFFSET_RESET);
            s_d.full_off = CW'(fifo_ctl_pkg::FULL_OFFSET_RESET);
        end
    end

    // ----------------------------------------------------------------
    // State register.
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            s_q <= '0;
            s_q.meta.mreset_n <= 1'b1;
            s_q.meta.preset_n <= 1'b1;
            s_q.meta.oe_n <= 1'b1;
            s_q.pin.mreset_n <= 1'b1;
            s_q.pin.preset_n <= 1'b1;
            s_q.pin.oe_n <= 1'b1;
            s_q.rd_sync <= 1'b1;
            s_q.wr_sync <= 1'b1;
            s_q.empty_off <= CW'(fifo_ctl_pkg::EMPTY_OFFSET_RESET);
            s_q.full_off <= CW'(fifo_ctl_pkg::FULL_OFFSET_RESET);
            s_q.af_now <= 1'b1;
            s_q.af_out <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs.
    // ----------------------------------------------------------------
    assign o_data_out = s_q.narrow
        ? {{(DW - NW){1'b0}}, s_q.out_data[NW-1:0]}
        : s_q.out_data;
    assign o_data_out_oe = !s_q.pin.oe_n;
    assign o_empty_flag = s_q.fall_thru ? !s_q.out_valid
        : !(s_q.count == '0 || s_q.rt_cnt != '0);
    assign o_full_flag = s_q.fall_thru ? mem_full : !mem_full;
    assign o_almost_empty_flag = s_q.ae_out;
    assign o_almost_full_flag = s_q.af_out;

endmodule // fifo_port_ctl

// *** rtl/fifo_ctl_pkg.sv ***
/*
 * Shared constants for the bus-matching FIFO port controller.
 * Assumes a single system clock; all pins are sampled by that clock.
 */
package fifo_ctl_pkg;

    // ----------------------------------------------------------------
    // Data widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 18;
    localparam int NARROW_W = 9;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam int EMPTY_OFFSET_RESET = 7;
    localparam int FULL_OFFSET_RESET = 7;

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    localparam int RT_ZERO_LAT_CYCLES = 1;
    localparam int RT_NORMAL_LAT_CYCLES = 3;

    // ----------------------------------------------------------------
    // Offset register selector for parallel access
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        SEL_EMPTY_OFFSET = 1'b0,
        SEL_FULL_OFFSET = 1'b1
    } offset_sel_e;

endpackage

// *** rtl/stream_buffer.sv ***
/*
 * Small valid/ready FIFO used as the write-side staging buffer.
 * Assumes one clock and a synchronous active-low reset.
 */
module stream_buffer #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic push;
    logic pop;

    assign o_in_ready = s_q.count != CW'(DEPTH);
    assign o_out_valid = s_q.count != '0;
    assign o_out_data = s_q.mem[s_q.rd_ptr];

    // ----------------------------------------------------------------
    // Pointer and count update.
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        if (push)
        begin
            s_d.mem[s_q.wr_ptr] = i_in_data;
            s_d.wr_ptr = (s_q.wr_ptr == AW'(DEPTH - 1)) ? '0
                : s_q.wr_ptr + AW'(1);
        end
        if (pop)
        begin
            s_d.rd_ptr = (s_q.rd_ptr == AW'(DEPTH - 1)) ? '0
                : s_q.rd_ptr + AW'(1);
        end
        if (push && !pop)
        begin
            s_d.count = s_q.count + CW'(1);
        end
        else if (pop && !push)
        begin
            s_d.count = s_q.count - CW'(1);
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            s_q.wr_ptr <= '0;
            s_q.rd_ptr <= '0;
            s_q.count <= '0;
            s_q.mem <= s_d.mem;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule // stream_buffer

// *** test/fifo_port_ctl_sva.sv ***
/* Assertion checker for fifo_port_ctl, bound to its ports.
   Assumes straps stay steady once master reset has ended. */
module fifo_port_ctl_sva (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rstn,
    // Pins
    input wire logic i_master_reset_n,
    input wire logic i_partial_reset_n,
    input wire logic i_read_port_width_sel,
    input wire logic i_read_port_sync_sel,
    input wire logic i_first_word_fall_through,
    input wire logic i_read_clock,
    input wire logic i_read_enable_n,
    input wire logic i_output_enable_n,
    input wire logic i_retransmit_request_n,
    // Outputs
    input wire logic [17:0] o_data_out,
    input wire logic o_data_out_oe,
    input wire logic o_empty_flag,
    input wire logic o_full_flag,
    input wire logic o_almost_full_flag
);
    timeunit 1ns;
    timeprecision 100ps;
    logic narrow_q, fall_thru_q, rd_sync_q;
    // ----------------------------------------------------------------
    // Straps as caught during master reset.
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            narrow_q <= 1'b0;
            fall_thru_q <= 1'b0;
            rd_sync_q <= 1'b1;
        end
        else if (!i_master_reset_n)
        begin
            narrow_q <= i_read_port_width_sel;
            fall_thru_q <= i_first_word_fall_through;
            rd_sync_q <= i_read_port_sync_sel;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    chk_oe_drives: assert property (
        (!i_output_enable_n) [*6] |-> o_data_out_oe)
        else $error("data outputs not driven");
    chk_oe_releases: assert property (
        i_output_enable_n [*6] |-> !o_data_out_oe)
        else $error("data outputs not released");
    chk_narrow_upper: assert property (
        narrow_q && i_master_reset_n |-> o_data_out[17:9] == 9'h000)
        else $error("upper outputs used in narrow mode");
    chk_mreset_clears: assert property (
        (!i_master_reset_n) [*7] |-> o_data_out == 18'h00000)
        else $error("master reset left output data");
    chk_preset_clears: assert property (
        (!i_partial_reset_n && !fall_thru_q) [*7]
        |-> o_data_out == 18'h00000 && !o_empty_flag)
        else $error("partial reset left data or flag");
    chk_full_af_low: assert property (
        (!o_full_flag && !fall_thru_q) [*5] |-> !o_almost_full_flag)
        else $error("almost full high while full");
    chk_rt_shows_empty: assert property (
        $rose(i_read_clock) && !i_retransmit_request_n && !fall_thru_q
        && i_master_reset_n && i_partial_reset_n
        |-> ##[1:8] !o_empty_flag)
        else $error("retransmit did not show empty");
    chk_read_needs_en: assert property (
        (i_read_enable_n && rd_sync_q && !fall_thru_q && i_master_reset_n
        && i_partial_reset_n) [*8] |-> $stable(o_data_out))
        else $error("output changed without read enable");
endmodule // fifo_port_ctl_sva

bind fifo_port_ctl fifo_port_ctl_sva chk (.*);

// *** test/fifo_link_agent.sv ***
/* Producer and consumer at the FIFO pins; pin clocks at 80 ns.
   Assumes i_clock runs at 10 ns; each task drives one pin clock cycle. */
module fifo_link_agent (
    // System clock
    input wire logic i_clock,
    // Write side
    output logic o_write_clock,
    output logic o_write_enable_n,
    output logic [17:0] o_data,
    // Read side
    output logic o_read_clock,
    output logic o_read_enable_n,
    output logic o_retransmit_request_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        o_write_clock = 1'b0;
        o_write_enable_n = 1'b1;
        o_data = 18'h00000;
        o_read_clock = 1'b0;
        o_read_enable_n = 1'b1;
        o_retransmit_request_n = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    // Clock one word in; pin clock stands low between words.
    task automatic write_word(input logic [17:0] d, input logic en_n);
        o_data = d;
        o_write_enable_n = en_n;
        step(1);
        o_write_clock = 1'b1;
        step(4);
        o_write_clock = 1'b0;
        step(1);
        o_data = ~d;
        step(2);
    endtask
    // Clock one word out, optionally with retransmit.
    task automatic read_word(input logic en_n, input logic rt_n);
        o_read_enable_n = en_n;
        o_retransmit_request_n = rt_n;
        step(1);
        o_read_clock = 1'b1;
        step(4);
        o_read_clock = 1'b0;
        step(1);
        o_read_enable_n = 1'b1;
        o_retransmit_request_n = 1'b1;
        step(2);
    endtask
endmodule // fifo_link_agent

// *** test/fifo_port_ctl_tb_top.sv ***
/* Testbench for fifo_port_ctl: resets, offsets, data, flags, retransmit.
   Assumes the link agent drives the write and read pins. */
module fifo_port_ctl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock, i_rstn, mr_n, pr_n, width, load_n, wsync, flag_mode, oe_n;
    logic wclk, wen_n, rclk, ren_n, rewind_n, oe, empty, full, ae, af, rsync;
    logic [17:0] din, dout;
    int mismatches = 0;
    int total_checks = 0;
    fifo_port_ctl #(.MEM_DEPTH(16), .BUF_DEPTH(16)) uut (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_master_reset_n(mr_n),
        .i_partial_reset_n(pr_n), .i_read_port_width_sel(width),
        .i_flag_timing_sel(flag_mode), .i_retransmit_latency_sel(flag_mode),
        .i_read_port_sync_sel(rsync), .i_write_port_sync_sel(wsync),
        .i_write_clock(wclk), .i_write_enable_n(wen_n), .i_data_in(din),
        .i_read_clock(rclk), .i_read_enable_n(ren_n),
        .i_output_enable_n(oe_n), .i_retransmit_request_n(rewind_n),
        .i_offset_load_n(load_n), .i_serial_load_enable_n(1'b1),
        .i_first_word_fall_through(1'b0), .o_data_out(dout),
        .o_data_out_oe(oe), .o_empty_flag(empty), .o_full_flag(full),
        .o_almost_empty_flag(ae), .o_almost_full_flag(af));
    fifo_link_agent agent (
        .i_clock(i_clock), .o_write_clock(wclk), .o_write_enable_n(wen_n),
        .o_data(din), .o_read_clock(rclk), .o_read_enable_n(ren_n),
        .o_retransmit_request_n(rewind_n));
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic mreset(input logic [3:0] c);
        {width, load_n, wsync, flag_mode} = c;
        mr_n = 1'b0;
        repeat (8) @(posedge i_clock);
        #1 mr_n = 1'b1;
        repeat (6) @(posedge i_clock);
        #1;
    endtask
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial
    begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------
    initial
    begin
        {i_rstn, mr_n, pr_n, width, load_n, wsync, flag_mode, oe_n} = 8'h6D;
        rsync = 1'b1;
        repeat (3) @(posedge i_clock);
        #1 i_rstn = 1'b1;
        repeat (4) @(posedge i_clock);
        #1;
        check({dout[16:0], empty}, 18'h00000);
        check({14'h0000, full, ae, af, oe}, 18'h0000A);
        $display("test 1 reset values done");
        mreset(4'b0011);
        agent.write_word(18'h00002, 1'b0);
        agent.write_word(18'h00003, 1'b0);
        agent.read_word(1'b0, 1'b1);
        check(18'(dout[3:0]), 18'h00002);
        agent.read_word(1'b0, 1'b1);
        check(18'(dout[3:0]), 18'h00003);
        load_n = 1'b1;
        oe_n = 1'b0;
        $display("test 2 offsets done");
        agent.write_word(18'h2AAAA, 1'b0);
        check({16'h0000, ae, empty}, 18'h00001);
        agent.write_word(18'h15555, 1'b1);
        check(18'(ae), 18'h00000);
        agent.write_word(18'h15555, 1'b0);
        check({16'h0000, ae, oe}, 18'h00003);
        agent.read_word(1'b0, 1'b1);
        check(dout, 18'h2AAAA);
        agent.read_word(1'b0, 1'b1);
        agent.read_word(1'b0, 1'b1);
        check({dout[16:0], empty}, {17'h15555, 1'b0});
        $display("test 3 data and flags done");
        for (int i = 0; i < 16; i++)
        begin
            agent.write_word(18'h00100 + 18'(i), 1'b0);
            if (i == 11 || i == 12)
                check(18'(af), 18'(i == 11));
        end
        check(18'(full), 18'h00000);
        agent.write_word(18'h3FFFF, 1'b0);
        for (int i = 0; i < 17; i++)
        begin
            agent.read_word(1'b0, 1'b1);
            check(dout, 18'h00100 + 18'(i < 16 ? i : 15));
        end
        $display("test 4 fill and drain done");
        pr_n = 1'b0;
        repeat (7) @(posedge i_clock);
        #1 pr_n = 1'b1;
        repeat (6) @(posedge i_clock);
        #1;
        check({dout[16:0], empty}, 18'h00000);
        for (int i = 1; i < 4; i++)
        begin
            agent.write_word(18'(i * 17), 1'b0);
            if (i < 3)
                check(18'(ae), 18'(i == 2));
        end
        agent.read_word(1'b0, 1'b1);
        agent.read_word(1'b0, 1'b1);
        agent.read_word(1'b1, 1'b0);
        for (int i = 1; i < 4; i++)
        begin
            agent.read_word(1'b0, 1'b1);
            check(dout, 18'(i * 17));
        end
        $display("test 5 partial reset and retransmit done");
        rsync = 1'b0;
        mreset(4'b1100);
        agent.write_word(18'h3FFFF, 1'b0);
        agent.read_word(1'b0, 1'b1);
        check(dout, 18'h001FF);
        oe_n = 1'b1;
        repeat (8) @(posedge i_clock);
        #1;
        check(18'(oe), 18'h00000);
        $display("test 6 narrow read done");
        stop_test();
    end
endmodule // fifo_port_ctl_tb_top
